// >>> dpst_cfg.svh
`ifndef DPST_CFG_SVH
`define DPST_CFG_SVH

// Register byte offsets
`define DPST_OFF_ACTION    8'h00
`define DPST_OFF_SETPOINT  8'h04
`define DPST_OFF_UPPER     8'h08
`define DPST_OFF_LOWER     8'h0C
`define DPST_OFF_INTYPE    8'h10
`define DPST_OFF_ACCEL2    8'h14
`define DPST_OFF_DECEL2    8'h18
`define DPST_OFF_NETTERM   8'h1C
`define DPST_OFF_STATUS    8'h20
`define DPST_OFF_MEAS      8'h24
`define DPST_OFF_SPEED     8'h28
`define DPST_OFF_INFUNC    8'h40
`define DPST_OFF_OUTFUNC   8'h60

// Reset values
`define DPST_RST_ACTION    8'h00
`define DPST_RST_PCT       16'h270F
`define DPST_RST_INTYPE    2'h0
`define DPST_RST_RAMP      16'h0000
`define DPST_RST_FUNC      8'hFF

// Codes and limits
`define DPST_NO_FUNC       16'h270F
`define DPST_HALF_PCT      16'h01F4
`define DPST_FULL_PCT      16'h03E8
`define DPST_ACT_MIN       8'h28
`define DPST_ACT_MAX       8'h2B
`define DPST_CODE_X_SEL    8'h0E
`define DPST_CODE_UPPER    8'h0F
`define DPST_CODE_LOWER    8'h0E
`define DPST_CODE_FWD      8'h10
`define DPST_CODE_PID      8'h2F
`define DPST_CODE_NEG      8'h64

// Measured input scaling, ADC full scale is 20 mA / 10 V
`define DPST_RAW_4MA       12'h333
`define DPST_K_CUR         17'h04E25
`define DPST_K_V5          17'h07D00
`define DPST_K_V10         17'h03E84

// Control update period
`define DPST_UPDATE_US     1000
`define DPST_CLK_MHZ       100

// Status bit positions
`define DPST_ST_ACTIVE     0
`define DPST_ST_UPPER      1
`define DPST_ST_LOWER      2
`define DPST_ST_FWD        3
`define DPST_ST_XASSIGN    4

`endif

// >>> dpst_pkg.sv
package dpst_pkg;

  typedef enum logic [1:0]
  {
    DPST_IN_CUR_4_20 = 2'h0,
    DPST_IN_V_0_5    = 2'h1,
    DPST_IN_V_0_10   = 2'h2
  } dpst_in_type_t;

  // Percent in 0.1 % steps, 9999 means unused
  typedef logic [15:0] dpst_pct_t;

endpackage : dpst_pkg

// >>> dpst_top.sv
// Implementation choices: the AXI4-Lite register port and the register offsets.
`include "dpst_cfg.svh"

module dpst_top #(
  parameter int N_IN         = 7,
  parameter int N_OUT        = 3,
  parameter int UPDATE_CYCLES = `DPST_UPDATE_US * `DPST_CLK_MHZ
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Drive side
  input  wire logic [N_IN-1:0] term_in,
  input  wire logic [11:0] meas_raw,
  input  wire logic [15:0] main_speed_cmd,
  input  wire logic [15:0] pid_correction,
  input  wire logic        rot_forward,
  // Results
  output logic [15:0]      speed_cmd_out,
  output logic [15:0]      setpoint_pct,
  output logic [15:0]      meas_pct,
  output logic [N_OUT-1:0] out_term
);

  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  logic [7:0]  action_r;
  logic [15:0] setpoint_r;
  logic [15:0] upper_r;
  logic [15:0] lower_r;
  dpst_pkg::dpst_in_type_t intype_r;
  logic [15:0] accel2_r;
  logic [15:0] decel2_r;
  logic [N_IN-1:0] netterm_r;
  logic [7:0]  infunc_r  [N_IN];
  logic [7:0]  outfunc_r [N_OUT];

  // ----------------------------------------------------------------
  // Bus write channel
  // ----------------------------------------------------------------
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        do_write;
  logic        wr_ok;
  logic [31:0] wmask;

  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign do_write      = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                        input logic [31:0] d);
    merge = (old & ~m) | (d & m);
  endfunction : merge

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      else if (do_write)
        aw_hold_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      else if (do_write)
        w_hold_r <= 1'b0;
    end
  end

  always_comb
  begin
    wr_ok = 1'b0;
    if (awaddr_r[1:0] == 2'h0)
    begin
      unique case (awaddr_r)
        `DPST_OFF_ACTION, `DPST_OFF_SETPOINT, `DPST_OFF_UPPER, `DPST_OFF_LOWER,
        `DPST_OFF_INTYPE, `DPST_OFF_ACCEL2, `DPST_OFF_DECEL2, `DPST_OFF_NETTERM:
          wr_ok = 1'b1;
        default:
          wr_ok = (awaddr_r >= `DPST_OFF_INFUNC && awaddr_r < `DPST_OFF_INFUNC + 8'(4 * N_IN))
               || (awaddr_r >= `DPST_OFF_OUTFUNC
                   && awaddr_r < `DPST_OFF_OUTFUNC + 8'(4 * N_OUT));
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      action_r   <= `DPST_RST_ACTION;
      setpoint_r <= `DPST_RST_PCT;
      upper_r    <= `DPST_RST_PCT;
      lower_r    <= `DPST_RST_PCT;
      intype_r   <= dpst_pkg::dpst_in_type_t'(`DPST_RST_INTYPE);
      accel2_r   <= `DPST_RST_RAMP;
      decel2_r   <= `DPST_RST_RAMP;
      netterm_r  <= '0;
      for (int i = 0; i < N_IN; i++)
        infunc_r[i] <= `DPST_RST_FUNC;
      for (int i = 0; i < N_OUT; i++)
        outfunc_r[i] <= `DPST_RST_FUNC;
    end
    else if (do_write && wr_ok)
    begin
      unique case (awaddr_r)
        `DPST_OFF_ACTION:   action_r   <= 8'(merge({24'h0, action_r}, wmask, wdata_r));
        `DPST_OFF_SETPOINT: setpoint_r <= 16'(merge({16'h0, setpoint_r}, wmask, wdata_r));
        `DPST_OFF_UPPER:    upper_r    <= 16'(merge({16'h0, upper_r}, wmask, wdata_r));
        `DPST_OFF_LOWER:    lower_r    <= 16'(merge({16'h0, lower_r}, wmask, wdata_r));
        `DPST_OFF_INTYPE:
          intype_r <= dpst_pkg::dpst_in_type_t'(2'(merge({30'h0, intype_r}, wmask, wdata_r)));
        `DPST_OFF_ACCEL2:   accel2_r   <= 16'(merge({16'h0, accel2_r}, wmask, wdata_r));
        `DPST_OFF_DECEL2:   decel2_r   <= 16'(merge({16'h0, decel2_r}, wmask, wdata_r));
        `DPST_OFF_NETTERM:  netterm_r  <= N_IN'(merge(32'(netterm_r), wmask, wdata_r));
        default:
        begin
          for (int i = 0; i < N_IN; i++)
            if (awaddr_r == `DPST_OFF_INFUNC + 8'(4 * i))
              infunc_r[i] <= 8'(merge({24'h0, infunc_r[i]}, wmask, wdata_r));
          for (int i = 0; i < N_OUT; i++)
            if (awaddr_r == `DPST_OFF_OUTFUNC + 8'(4 * i))
              outfunc_r[i] <= 8'(merge({24'h0, outfunc_r[i]}, wmask, wdata_r));
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control update tick
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_r;
  logic        tick;

  assign tick = (tick_cnt_r == 32'(UPDATE_CYCLES - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_cnt_r <= 32'h0000_0000;
    else
      tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
  end

  // ----------------------------------------------------------------
  // Enable, scaling and limit flags
  // ----------------------------------------------------------------
  logic [N_IN-1:0] x_sel_map;
  logic [N_IN-1:0] term_eff;
  logic        x_assigned;
  logic        active_nxt;
  logic [28:0] prod;
  logic [15:0] meas_nxt;
  logic        active_r;
  logic        upper_flag_r;
  logic        lower_flag_r;

  always_comb
  begin
    for (int i = 0; i < N_IN; i++)
      x_sel_map[i] = (infunc_r[i] == `DPST_CODE_X_SEL);
  end

  assign term_eff   = term_in | netterm_r;
  assign x_assigned = |x_sel_map;
  assign active_nxt = (action_r >= `DPST_ACT_MIN) && (action_r <= `DPST_ACT_MAX)
                   && (!x_assigned || |(x_sel_map & term_eff));

  always_comb
  begin
    unique case (intype_r)
      dpst_pkg::DPST_IN_CUR_4_20:
        prod = (meas_raw > `DPST_RAW_4MA)
             ? 29'(meas_raw - `DPST_RAW_4MA) * 29'(`DPST_K_CUR) : 29'h0;
      dpst_pkg::DPST_IN_V_0_5:
        prod = 29'(meas_raw) * 29'(`DPST_K_V5);
      dpst_pkg::DPST_IN_V_0_10:
        prod = 29'(meas_raw) * 29'(`DPST_K_V10);
      default:
        prod = 29'h0;
    endcase
    meas_nxt = (prod[28:16] > 13'(`DPST_FULL_PCT)) ? `DPST_FULL_PCT : {3'h0, prod[28:16]};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      active_r     <= 1'b0;
      meas_pct     <= 16'h0000;
      upper_flag_r <= 1'b0;
      lower_flag_r <= 1'b0;
    end
    else if (tick)
    begin
      active_r     <= active_nxt;
      meas_pct     <= meas_nxt;
      upper_flag_r <= active_nxt && upper_r != `DPST_NO_FUNC && meas_nxt > upper_r;
      lower_flag_r <= active_nxt && lower_r != `DPST_NO_FUNC && meas_nxt < lower_r;
    end
  end

  // Setpoint presented to the PID arithmetic
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      setpoint_pct <= `DPST_HALF_PCT;
    else if (setpoint_r == `DPST_NO_FUNC)
      setpoint_pct <= `DPST_HALF_PCT;
    else
      setpoint_pct <= (setpoint_r > `DPST_FULL_PCT) ? `DPST_FULL_PCT : setpoint_r;
  end

  // ----------------------------------------------------------------
  // Main speed ramp and overlay
  // ----------------------------------------------------------------
  logic [15:0] ramp_r;
  logic [15:0] step_cnt_r;
  logic [15:0] interval;
  logic [16:0] sum;

  assign interval = (main_speed_cmd > ramp_r) ? accel2_r : decel2_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ramp_r     <= 16'h0000;
      step_cnt_r <= 16'h0000;
    end
    else if (!active_r)
    begin
      ramp_r     <= main_speed_cmd;
      step_cnt_r <= 16'h0000;
    end
    else if (tick && ramp_r != main_speed_cmd)
    begin
      if (step_cnt_r >= interval)
      begin
        step_cnt_r <= 16'h0000;
        ramp_r     <= (main_speed_cmd > ramp_r) ? ramp_r + 16'h0001 : ramp_r - 16'h0001;
      end
      else
        step_cnt_r <= step_cnt_r + 16'h0001;
    end
  end

  // Correction is a signed offset added to the ramped speed
  assign sum = 17'(ramp_r) + 17'(signed'(pid_correction));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      speed_cmd_out <= 16'h0000;
    else if (!active_r)
      speed_cmd_out <= main_speed_cmd;
    else if (pid_correction[15] && sum[16])
      speed_cmd_out <= 16'h0000;
    else if (!pid_correction[15] && sum[16])
      speed_cmd_out <= 16'hFFFF;
    else
      speed_cmd_out <= sum[15:0];
  end

  // ----------------------------------------------------------------
  // Output terminals
  // ----------------------------------------------------------------
  logic [7:0] base_code [N_OUT];
  logic [N_OUT-1:0] neg;
  logic [N_OUT-1:0] level;

  always_comb
  begin
    for (int i = 0; i < N_OUT; i++)
    begin
      neg[i]       = outfunc_r[i] >= `DPST_CODE_NEG;
      base_code[i] = neg[i] ? outfunc_r[i] - `DPST_CODE_NEG : outfunc_r[i];
      unique case (base_code[i])
        `DPST_CODE_UPPER: level[i] = upper_flag_r;
        `DPST_CODE_LOWER: level[i] = lower_flag_r;
        `DPST_CODE_FWD:   level[i] = rot_forward;
        `DPST_CODE_PID:   level[i] = active_r;
        default:          level[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      out_term <= '0;
    else
      out_term <= level ^ neg;
  end

  // ----------------------------------------------------------------
  // Bus read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  logic        rd_ok;

  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      `DPST_OFF_ACTION:   rd_val = {24'h0, action_r};
      `DPST_OFF_SETPOINT: rd_val = {16'h0, setpoint_r};
      `DPST_OFF_UPPER:    rd_val = {16'h0, upper_r};
      `DPST_OFF_LOWER:    rd_val = {16'h0, lower_r};
      `DPST_OFF_INTYPE:   rd_val = {30'h0, intype_r};
      `DPST_OFF_ACCEL2:   rd_val = {16'h0, accel2_r};
      `DPST_OFF_DECEL2:   rd_val = {16'h0, decel2_r};
      `DPST_OFF_NETTERM:  rd_val = 32'(netterm_r);
      `DPST_OFF_STATUS:
      begin
        rd_val[`DPST_ST_ACTIVE]  = active_r;
        rd_val[`DPST_ST_UPPER]   = upper_flag_r;
        rd_val[`DPST_ST_LOWER]   = lower_flag_r;
        rd_val[`DPST_ST_FWD]     = rot_forward;
        rd_val[`DPST_ST_XASSIGN] = x_assigned;
      end
      `DPST_OFF_MEAS:     rd_val = {16'h0, meas_pct};
      `DPST_OFF_SPEED:    rd_val = {16'h0, speed_cmd_out};
      default:
      begin
        rd_ok = 1'b0;
        for (int i = 0; i < N_IN; i++)
          if (s_axi_araddr == `DPST_OFF_INFUNC + 8'(4 * i))
          begin
            rd_val = {24'h0, infunc_r[i]};
            rd_ok  = 1'b1;
          end
        for (int i = 0; i < N_OUT; i++)
          if (s_axi_araddr == `DPST_OFF_OUTFUNC + 8'(4 * i))
          begin
            rd_val = {24'h0, outfunc_r[i]};
            rd_ok  = 1'b1;
          end
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_ok ? rd_val : 32'h0000_0000;
      s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : dpst_top

// >>> dpst_chk_asserts.sv
module dpst_chk #(
  parameter int UPDATE_CYCLES = 8
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // Results
  input wire logic [15:0] setpoint_pct,
  input wire logic [15:0] meas_pct
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic        wr_hs;
  logic        sp_wr;
  logic [15:0] sp_r;
  logic [3:0]  gap_r;
  assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign sp_wr = wr_hs && s_axi_awaddr == 8'h04 && s_axi_wstrb == 4'hF;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sp_r <= 16'h0000;
    else if (sp_wr)
      sp_r <= s_axi_wdata[15:0];
  end

  // Cycles since the scaled measurement last moved
  always_ff @(posedge aclk)
  begin
    if (!aresetn || $changed(meas_pct))
      gap_r <= 4'h0;
    else if (gap_r != 4'hF)
      gap_r <= gap_r + 4'h1;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  wr_answer_a: assert property (wr_hs |-> ##2 s_axi_bvalid)
    else $error("write response late");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  set_point_a: assert property (
    sp_wr && s_axi_wdata[15:0] <= 16'h03E8 |=> ##[0:2] setpoint_pct == sp_r)
    else $error("setpoint not applied");
  set_half_a: assert property (
    sp_wr && s_axi_wdata[15:0] == 16'h270F |-> ##[1:3] setpoint_pct == 16'h01F4)
    else $error("default setpoint wrong");
  meas_range_a: assert property (meas_pct <= 16'h03E8)
    else $error("measurement above full scale");
  meas_tick_a: assert property ($changed(meas_pct) |-> gap_r >= UPDATE_CYCLES - 2)
    else $error("measurement moved between updates");
endmodule : dpst_chk

bind dpst_top dpst_chk #(.UPDATE_CYCLES(UPDATE_CYCLES)) chk_i (.*);

// >>> dpst_det.sv
module dpst_det (
  // Clock
  input wire logic        aclk,
  // Roller position as converter code
  input wire logic [11:0] target,
  input wire logic        slow,
  // Analog input
  output logic [11:0]     meas_raw
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Roller travel, jumping or slewing
  // ----------------------------------------
  initial meas_raw = 12'h000;
  always @(posedge aclk)
  begin
    if (!slow || meas_raw == target)
      meas_raw <= target;
    else if (meas_raw < target)
      meas_raw <= meas_raw + 12'h001;
    else
      meas_raw <= meas_raw - 12'h001;
  end
endmodule : dpst_det

// >>> tb_dancer_pid_speed_trim.sv
module tb_dancer_pid_speed_trim;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UPC = 8;
  localparam logic [15:0] SPV [4] = '{16'h00FA, 16'h0000, 16'h03E8, 16'h270F};
  localparam logic [7:0]  ACT [6] = '{8'h00, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C};
  localparam logic [11:0] RAW [3] = '{12'hB32, 12'h4CD, 12'h800};
  localparam logic [29:0] SCL [8] = '{{2'd0, 12'h333, 16'h0}, {2'd0, 12'h999, 16'h1F4},
    {2'd0, 12'hFFF, 16'h3E8}, {2'd1, 12'h000, 16'h0}, {2'd1, 12'h400, 16'h1F4},
    {2'd1, 12'h800, 16'h3E8}, {2'd2, 12'h800, 16'h1F4}, {2'd2, 12'hFFF, 16'h3E8}};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rot_forward = 1'b0, slow = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [6:0]  term_in = 7'h00;
  logic [11:0] meas_raw, target = 12'h000;
  logic [15:0] main_speed_cmd = 16'h0, pid_correction = 16'h0;
  logic [15:0] speed_cmd_out, setpoint_pct, meas_pct;
  logic [2:0]  out_term;
  logic [7:0]  oc [3];
  logic [33:0] exp_q [$];
  int          n_errors = 0, samples_checked = 0, seed = 58384;

  always #5 aclk = ~aclk;
  dpst_top #(.UPDATE_CYCLES(UPC)) dut (.*);
  dpst_det det (.aclk(aclk), .target(target), .slow(slow), .meas_raw(meas_raw));

  // ----------------------------------------
  // Comparison and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd

  always @(posedge aclk)
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());

  // Terminal level for a function code, given the flags
  function automatic logic ob(input logic [7:0] c, input logic u, l, f, a);
    logic v;
    case (c >= 8'h64 ? c - 8'h64 : c)
      8'h0E: v = l;
      8'h0F: v = u;
      8'h10: v = f;
      8'h2F: v = a;
      default: v = 1'b0;
    endcase
    return v ^ (c >= 8'h64);
  endfunction : ob

  task automatic so(input logic [7:0] c0, c1, c2);
    oc = '{c0, c1, c2};
    for (int k = 0; k < 3; k++)
      wr(8'h60 + 8'(4 * k), {24'h0, oc[k]}, 2'b00);
  endtask : so

  task automatic st(input logic u, l, a, s);
    for (int k = 0; k < 3; k++)
      chk(out_term[k], ob(oc[k], u, l, rot_forward, a));
    rd(8'h20, {27'h0, s, rot_forward, l, u, a});
  endtask : st

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  initial
  begin
    wt(20000);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    int i, j;
    logic a;
    logic [15:0] m, tg;
    wt(6);
    aresetn <= 1'b1;
    rd(8'h00, 34'h0);
    for (i = 0; i < 3; i++)
      rd(8'(4 + 4 * i), 34'h270F);
    rd(8'h10, 34'h0);
    rd(8'h40, 34'hFF);
    rd(8'h60, 34'hFF);
    rd(8'h30, {2'b10, 32'h0});
    wr(8'h30, 32'h1, 2'b10);
    chk(setpoint_pct, 16'h01F4);
    $display("reset test done");
    for (i = 0; i < 4; i++)
    begin
      wr(8'h04, {16'h0, SPV[i]}, 2'b00);
      wt(3);
      chk(setpoint_pct, SPV[i] == 16'h270F ? 16'h01F4 : SPV[i]);
    end
    $display("setpoint test done");
    // Secondary ramp times stay at zero seconds within this block
    m = 16'h4000 + (16'($random(seed)) & 16'h0FFF);
    main_speed_cmd <= m;
    so(8'h2F, 8'h93, 8'h10);
    for (i = 0; i < 6; i++)
    begin
      a = ACT[i] >= 8'h28 && ACT[i] <= 8'h2B;
      rot_forward <= 1'($random(seed));
      pid_correction <= (16'($random(seed)) & 16'h00FF) - 16'h0080;
      wr(8'h00, {24'h0, ACT[i]}, 2'b00);
      wt(2 * UPC + 3);
      st(1'b0, 1'b0, a, 1'b0);
      chk(speed_cmd_out, a ? 16'(m + pid_correction) : m);
    end
    $display("selection test done");
    wr(8'h00, 32'h28, 2'b00);
    wr(8'h18, 32'h1, 2'b00);
    // Let the next update tick switch dancer control on first
    wt(2 * UPC);
    for (j = 0; j < 2; j++)
    begin
      tg = j ? m : m + 16'h0004;
      main_speed_cmd <= tg;
      wt(UPC + 2);
      chk(j ? speed_cmd_out > tg + pid_correction : speed_cmd_out < tg + pid_correction,
          1);
      wt(10 * UPC);
      chk(speed_cmd_out, 16'(tg + pid_correction));
    end
    $display("ramp test done");
    wr(8'h10, 32'h2, 2'b00);
    for (j = 0; j < 2; j++)
    begin
      so(j ? 8'h73 : 8'h0F, j ? 8'h0E : 8'h72, j ? 8'h10 : 8'h74);
      wr(8'h08, j ? 32'h270F : 32'h258, 2'b00);
      wr(8'h0C, j ? 32'h270F : 32'h190, 2'b00);
      for (i = 0; i < 3; i++)
      begin
        target <= RAW[i];
        rot_forward <= 1'($random(seed));
        wt(2 * UPC + 3);
        st(!j && i == 0, !j && i == 1, 1'b1, 1'b0);
      end
    end
    $display("limit test done");
    for (i = 0; i < 8; i++)
    begin
      wr(8'h10, {30'h0, SCL[i][29:28]}, 2'b00);
      target <= SCL[i][27:16];
      wt(2 * UPC + 3);
      rd(8'h24, {18'h0, SCL[i][15:0]});
    end
    slow <= 1'b1;
    target <= 12'h000;
    wt(4 * UPC);
    slow <= 1'b0;
    $display("scaling test done");
    j = $unsigned($random(seed)) % 7;
    wr(8'h40 + 8'(4 * j), 32'hE, 2'b00);
    for (i = 0; i < 3; i++)
    begin
      term_in <= (7'($random(seed)) & ~(7'h1 << j)) | (i == 1 ? 7'h1 << j : 7'h0);
      wr(8'h1C, i == 2 ? 32'h1 << j : 32'h0, 2'b00);
      wt(2 * UPC + 3);
      st(1'b0, 1'b0, i != 0, 1'b1);
    end
    $display("enable test done");
    wt(3);
    summarize();
  end
endmodule : tb_dancer_pid_speed_trim
